// >>> common/can_swk_pkg.sv
// can_swk_pkg: constants and types for the selective wake mode controller.
// assumes a single 100 MHz clock and an 8-bit register port.
`default_nettype none

package can_swk_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] MODE_ADDR = 4'h0;   // mode field, bits 2:0
  localparam logic [3:0] STATUS_ADDR = 4'h1; // flags, read only
  localparam logic [3:0] CTRL_ADDR = 4'h2;   // config valid, error clear
  localparam logic [3:0] STATE_ADDR = 4'h3;  // one-hot transceiver state
  localparam logic [7:0] MODE_RESET = 8'h00;

  // status bit positions
  localparam int STAT_SIL_BIT = 0;
  localparam int STAT_SYNC_BIT = 1;
  localparam int STAT_ARMED_BIT = 2;
  localparam int STAT_ERR_BIT = 3;
  localparam int STAT_CFGV_BIT = 4;
  // control bit positions
  localparam int CTRL_CFGV_BIT = 0;
  localparam int CTRL_ERRCLR_BIT = 1;

  // ----------------------------------------------------------------
  // mode field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_OFF0 = 3'h0;
  localparam logic [2:0] MODE_WK = 3'h1;
  localparam logic [2:0] MODE_RXO = 3'h2;
  localparam logic [2:0] MODE_NORM = 3'h3;
  localparam logic [2:0] MODE_OFF1 = 3'h4;
  localparam logic [2:0] MODE_SWK = 3'h5;
  localparam logic [2:0] MODE_RXO_SWK = 3'h6;
  localparam logic [2:0] MODE_NORM_SWK = 3'h7;

  // chip operating modes seen on chip_mode_i
  localparam logic [1:0] CHIP_NORMAL = 2'h0;
  localparam logic [1:0] CHIP_STOP = 2'h1;
  localparam logic [1:0] CHIP_SLEEP = 2'h2;
  localparam logic [1:0] CHIP_RESTART = 2'h3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_FILTER_NS = 500; // dominant filter time, plain default
  localparam int WAKE_CNT_W = 8;
  localparam logic [7:0] WAKE_FILTER_CYC =
    8'((WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    XS_OFF = 7'h01, XS_ACTIVE = 7'h02, XS_WK = 7'h04, XS_WUF = 7'h08,
    XS_WUP1 = 7'h10, XS_WUP2 = 7'h20, XS_WOKEN = 7'h40
  } xcvr_state_type;

  typedef enum logic [3:0] {
    WS_IDLE = 4'h1, WS_DOM1 = 4'h2, WS_REC = 4'h4, WS_DOM2 = 4'h8
  } wup_state_type;

endpackage : can_swk_pkg

`default_nettype wire

// >>> core/can_swk_mode_ctrl.sv
// can_swk_mode_ctrl: transceiver mode decode, low-power mapping and status
// flags of a CAN transceiver with selective wake.
// assumes frame checker, error counter and silence timer sit outside and
// deliver one-cycle event pulses synchronous to clk_i.
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module can_swk_mode_ctrl (
  input wire logic clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // chip operating mode
  input wire logic [1:0] chip_mode_i,
  // bus side events
  input wire logic frame_ok_i,        // frame without crc or stuff error
  input wire logic id_match_i,        // masked identifier matched
  input wire logic dlc_match_i,       // data_length_code equal
  input wire logic data_match_i,      // data mask hit
  input wire logic proto_err_i,       // protocol error seen
  input wire logic silence_expired_i, // silence timeout pulse
  input wire logic protocol_error_count_overflow_i,   // protocol_error_count overflow
  input wire logic bus_dominant_i,    // bus level
  input wire logic bus_rx_i,          // received bus bit
  input wire logic txd_i,             // transmit data from host
  // outputs
  output logic txd_bus_o,             // drive to bus, 1 = recessive
  output logic rxd_o,                 // receive data to host
  output logic wake_irq_o,            // wake interrupt pulse
  output logic restart_req_o          // restart request pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    can_swk_pkg::xcvr_state_type state; // operating state
    logic [2:0] mode;                   // programmed mode field
    logic sil;                          // bus_silence_flag
    logic sync;                         // frame-sync flag
    logic armed;                        // wake_armed_flag
    logic err;                          // config_or_overflow_error
    logic cfgv;                         // config_valid_bit
    logic [1:0] chip_prev;              // chip mode last cycle
    logic [7:0] rdata;                  // read data register
    logic irq;                          // wake interrupt pulse
    logic restart;                      // restart request pulse
    logic txd;                          // registered bus drive
    logic rxd;                          // registered receive data
  } ctl_type;

  ctl_type s;
  ctl_type n;

  logic wup_pulse;     // wake pattern found
  logic wake_frame;    // qualified wake_frame
  logic wup_enable;    // pattern detection running
  logic enter_stop;    // chip just entered stop
  logic enter_sleep;   // chip just entered sleep
  logic in_normal;     // chip in normal mode
  logic mode_wr;       // accepted mode write
  logic ctrl_wr;       // control write
  logic swk_on;        // selective wake enabled, no error

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // operating state for a mode code, error flag and chip mode
  function automatic can_swk_pkg::xcvr_state_type target_state(
    input logic [2:0] code, input logic err, input logic [1:0] chip);
    target_state = can_swk_pkg::XS_OFF;
    case (code)
      can_swk_pkg::MODE_WK: target_state = can_swk_pkg::XS_WK;
      can_swk_pkg::MODE_RXO: target_state = can_swk_pkg::XS_ACTIVE;
      can_swk_pkg::MODE_NORM: begin
        // normal code only operates wake-capable in stop
        if (chip == can_swk_pkg::CHIP_STOP) begin
          target_state = can_swk_pkg::XS_WK;
        end else begin
          target_state = can_swk_pkg::XS_ACTIVE;
        end
      end
      can_swk_pkg::MODE_SWK: begin
        // with error the wake runs without frame detection
        target_state = err ? can_swk_pkg::XS_WUP2 : can_swk_pkg::XS_WUF;
      end
      can_swk_pkg::MODE_RXO_SWK, can_swk_pkg::MODE_NORM_SWK: begin
        target_state = can_swk_pkg::XS_ACTIVE;
      end
      default: target_state = can_swk_pkg::XS_OFF;
    endcase
  endfunction : target_state

  // codes that carry selective wake
  function automatic logic is_swk(input logic [2:0] code);
    is_swk = code[2] && (code[1:0] != 2'b00);
  endfunction : is_swk

  // ----------------------------------------------------------------
  // combinational terms
  // ----------------------------------------------------------------
  assign in_normal = chip_mode_i == can_swk_pkg::CHIP_NORMAL;
  assign enter_stop = chip_mode_i == can_swk_pkg::CHIP_STOP &&
                      s.chip_prev != can_swk_pkg::CHIP_STOP;
  assign enter_sleep = chip_mode_i == can_swk_pkg::CHIP_SLEEP &&
                       s.chip_prev != can_swk_pkg::CHIP_SLEEP;
  assign mode_wr = wr_i && in_normal && addr_i == can_swk_pkg::MODE_ADDR;
  assign ctrl_wr = wr_i && addr_i == can_swk_pkg::CTRL_ADDR;
  assign swk_on = s.mode[2] && !s.err;
  assign wake_frame = frame_ok_i && id_match_i && dlc_match_i && data_match_i;
  assign wup_enable = s.state inside {can_swk_pkg::XS_WK, can_swk_pkg::XS_WUF,
                                      can_swk_pkg::XS_WUP1, can_swk_pkg::XS_WUP2};

  // wake pattern detector
  wake_pattern_detect u_wup (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .enable_i(wup_enable),
    .bus_dominant_i(bus_dominant_i),
    .wake_pattern_o(wup_pulse)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    n.irq = 1'b0;
    n.restart = 1'b0;
    n.chip_prev = chip_mode_i;

    // software: control register, config valid and error clear
    if (ctrl_wr) begin
      n.cfgv = wdata_i[can_swk_pkg::CTRL_CFGV_BIT];
      if (wdata_i[can_swk_pkg::CTRL_ERRCLR_BIT]) begin
        n.err = 1'b0;
      end
    end

    // software: mode field, only in chip normal
    if (mode_wr) begin
      n.mode = wdata_i[2:0];
      // a woken transceiver stays woken until a different code arrives
      if (s.state != can_swk_pkg::XS_WOKEN || wdata_i[2:0] != s.mode) begin
        // entering a wake code runs the configuration check
        if (is_swk(wdata_i[2:0]) && !is_swk(s.mode)) begin
          if (s.cfgv) begin
            n.err = 1'b0;
            n.armed = 1'b1;
          end else begin
            n.err = 1'b1;
          end
        end
        n.state = target_state(wdata_i[2:0], n.err, chip_mode_i);
        if (n.state == can_swk_pkg::XS_WUP2) begin
          n.armed = 1'b1;
        end
      end
      if (!wdata_i[2]) begin
        n.armed = 1'b0;
      end
    end

    // stop entry: field untouched, state remapped unless woken
    if (enter_stop && s.state != can_swk_pkg::XS_WOKEN) begin
      n.state = target_state(s.mode, s.err, can_swk_pkg::CHIP_STOP);
    end

    // sleep entry: low bits rewritten, woken transceiver rearmed
    if (enter_sleep) begin
      // no dependency on the sync flag here
      case (s.mode)
        can_swk_pkg::MODE_RXO, can_swk_pkg::MODE_NORM: begin
          n.mode = can_swk_pkg::MODE_WK;
          n.state = can_swk_pkg::XS_WK;
        end
        can_swk_pkg::MODE_WK: n.state = can_swk_pkg::XS_WK;
        can_swk_pkg::MODE_SWK, can_swk_pkg::MODE_RXO_SWK,
        can_swk_pkg::MODE_NORM_SWK: begin
          n.mode = {s.mode[2], 2'b01};
          n.state = s.err ? can_swk_pkg::XS_WK : can_swk_pkg::XS_WUF;
          n.armed = !s.err;
        end
        default: n.state = can_swk_pkg::XS_OFF;
      endcase
    end

    // frame sync tracking; a clean frame wins over an error
    if (s.state == can_swk_pkg::XS_ACTIVE || s.state == can_swk_pkg::XS_WUF) begin
      if (proto_err_i) begin
        n.sync = 1'b0;
      end
      if (frame_ok_i) begin
        n.sync = 1'b1;
      end
    end

    // bus events per operating state
    case (s.state)
      can_swk_pkg::XS_ACTIVE: begin
        // bus traffic passes; wake block only watches
        if (swk_on && protocol_error_count_overflow_i) begin
          n.err = 1'b1;
          n.armed = 1'b0;
          n.irq = 1'b1;
        end else if (swk_on && wake_frame) begin
          n.irq = 1'b1;
          n.armed = 1'b0;
        end
      end
      can_swk_pkg::XS_WK: begin
        // plain wake-capable: any pattern wakes
        if (wup_pulse) begin
          n.state = can_swk_pkg::XS_WOKEN;
          n.irq = in_normal || chip_mode_i == can_swk_pkg::CHIP_STOP;
          n.restart = chip_mode_i == can_swk_pkg::CHIP_SLEEP;
        end
      end
      can_swk_pkg::XS_WUF: begin
        if (protocol_error_count_overflow_i) begin
          n.err = 1'b1;
          n.armed = 1'b0;
          n.state = can_swk_pkg::XS_WOKEN;
          n.irq = chip_mode_i != can_swk_pkg::CHIP_SLEEP;
          n.restart = chip_mode_i == can_swk_pkg::CHIP_SLEEP;
        end else if (wake_frame) begin
          n.armed = 1'b0;
          n.state = can_swk_pkg::XS_WOKEN;
          if (chip_mode_i == can_swk_pkg::CHIP_SLEEP) begin
            n.restart = 1'b1;
            n.cfgv = 1'b0;
          end else begin
            n.irq = 1'b1;
          end
        end else if (silence_expired_i) begin
          n.sil = 1'b1;
          n.state = can_swk_pkg::XS_WUP1;
        end
        if (wup_pulse) begin
          n.sil = 1'b0;
        end
      end
      can_swk_pkg::XS_WUP1: begin
        // a pattern after silence returns to frame detection
        if (wup_pulse) begin
          n.sil = 1'b0;
          n.state = can_swk_pkg::XS_WUF;
        end
      end
      can_swk_pkg::XS_WUP2: begin
        // after an error: no frame detection, pattern wakes
        if (wup_pulse) begin
          n.sil = 1'b0;
          n.armed = 1'b0;
          n.state = can_swk_pkg::XS_WOKEN;
          n.irq = chip_mode_i != can_swk_pkg::CHIP_SLEEP;
          n.restart = chip_mode_i == can_swk_pkg::CHIP_SLEEP;
        end else if (silence_expired_i) begin
          n.sil = 1'b1;
        end
      end
      default: begin
        // off and woken ignore bus events
      end
    endcase

    // bus drive: only a normal code transmits
    n.txd = (s.state == can_swk_pkg::XS_ACTIVE && s.mode[1:0] == 2'b11) ? txd_i : 1'b1;
    if (s.state == can_swk_pkg::XS_ACTIVE) begin
      n.rxd = bus_rx_i;
    end else begin
      n.rxd = !(s.state == can_swk_pkg::XS_WOKEN && !in_normal);
    end

    // read data, valid the cycle after the strobe
    n.rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        can_swk_pkg::MODE_ADDR: n.rdata = {5'h00, s.mode};
        can_swk_pkg::STATUS_ADDR: n.rdata = {3'h0, s.cfgv, s.err, s.armed, s.sync, s.sil};
        can_swk_pkg::CTRL_ADDR: n.rdata = {7'h00, s.cfgv};
        can_swk_pkg::STATE_ADDR: n.rdata = {1'b0, s.state};
        default: n.rdata = 8'h00;
      endcase
    end
  end

  // register the state copy
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s <= '{state: can_swk_pkg::XS_OFF, mode: can_swk_pkg::MODE_RESET[2:0],
             sil: 1'b0, sync: 1'b0, armed: 1'b0, err: 1'b0, cfgv: 1'b0,
             chip_prev: can_swk_pkg::CHIP_NORMAL, rdata: 8'h00, irq: 1'b0,
             restart: 1'b0, txd: 1'b1, rxd: 1'b1};
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o = s.rdata;
  assign txd_bus_o = s.txd;
  assign rxd_o = s.rxd;
  assign wake_irq_o = s.irq;
  assign restart_req_o = s.restart;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_sil_set;
    @(posedge clk_i) disable iff (!resetn_i)
    s.state == can_swk_pkg::XS_WUP2 && silence_expired_i && !wup_pulse |=> s.sil;
  endproperty
  a_sil_set: assert property (p_sil_set) else $error("silence not flagged");

  property p_sil_clr;
    @(posedge clk_i) disable iff (!resetn_i)
    wup_pulse && s.state == can_swk_pkg::XS_WUP1 |=> !s.sil ##0 s.state == can_swk_pkg::XS_WUF;
  endproperty
  a_sil_clr: assert property (p_sil_clr) else $error("pattern left silence set");

  property p_sync_set;
    @(posedge clk_i) disable iff (!resetn_i)
    s.state == can_swk_pkg::XS_WUF && frame_ok_i |=> s.sync;
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync not set");

  property p_sync_clr;
    @(posedge clk_i) disable iff (!resetn_i)
    s.state == can_swk_pkg::XS_ACTIVE && proto_err_i && !frame_ok_i |=> !s.sync;
  endproperty
  a_sync_clr: assert property (p_sync_clr) else $error("sync not cleared");

  property p_mode_locked;
    @(posedge clk_i) disable iff (!resetn_i)
    chip_mode_i == can_swk_pkg::CHIP_STOP && s.chip_prev == can_swk_pkg::CHIP_STOP |=> $stable(s.mode);
  endproperty
  a_mode_locked: assert property (p_mode_locked) else $error("mode changed in stop");

  property p_sleep_map;
    @(posedge clk_i) disable iff (!resetn_i)
    enter_sleep && s.mode == can_swk_pkg::MODE_NORM |=> s.mode == can_swk_pkg::MODE_WK && s.state == can_swk_pkg::XS_WK;
  endproperty
  a_sleep_map: assert property (p_sleep_map) else $error("sleep mapping wrong");

  property p_stop_keep;
    @(posedge clk_i) disable iff (!resetn_i)
    enter_stop && s.state != can_swk_pkg::XS_WOKEN && s.mode == can_swk_pkg::MODE_NORM
    |=> s.state == can_swk_pkg::XS_WK && s.mode == can_swk_pkg::MODE_NORM;
  endproperty
  a_stop_keep: assert property (p_stop_keep) else $error("stop mapping wrong");

  property p_frame_wake;
    @(posedge clk_i) disable iff (!resetn_i)
    s.state == can_swk_pkg::XS_WUF && wake_frame && !protocol_error_count_overflow_i && !ctrl_wr &&
    chip_mode_i == can_swk_pkg::CHIP_SLEEP && !enter_sleep
    |=> restart_req_o && !s.cfgv && !s.armed && s.err == $past(s.err) ##1 !restart_req_o;
  endproperty
  a_frame_wake: assert property (p_frame_wake) else $error("sleep wake frame handling wrong");

  property p_rx_only;
    @(posedge clk_i) disable iff (!resetn_i)
    s.state == can_swk_pkg::XS_ACTIVE && s.mode[1:0] == 2'b10 |=> txd_bus_o;
  endproperty
  a_rx_only: assert property (p_rx_only) else $error("receive-only drove bus");

endmodule : can_swk_mode_ctrl

`default_nettype wire

// >>> core/wake_pattern_detect.sv
// wake_pattern_detect: finds two filtered dominant phases split by recessive.
// assumes bus_dominant_i is synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module wake_pattern_detect (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic enable_i,        // detection armed
  input wire logic bus_dominant_i,  // bus level, 1 = dominant
  output logic wake_pattern_o       // one-cycle pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    can_swk_pkg::wup_state_type st;                  // phase tracker
    logic [can_swk_pkg::WAKE_CNT_W-1:0] cnt;         // dominant length
    logic hit;                                       // pattern pulse
  } wup_ctl_type;

  wup_ctl_type s;
  wup_ctl_type n;

  // next state: each dominant phase must reach the filter count
  always_comb begin
    n = s;
    n.hit = 1'b0;
    if (!enable_i) begin
      n.st = can_swk_pkg::WS_IDLE;
      n.cnt = '0;
    end else begin
      case (s.st)
        can_swk_pkg::WS_IDLE: begin
          if (bus_dominant_i) begin
            n.st = can_swk_pkg::WS_DOM1;
            n.cnt = 8'h01;
          end
        end
        can_swk_pkg::WS_DOM1: begin
          if (bus_dominant_i) begin
            // saturate at the filter count
            if (s.cnt < can_swk_pkg::WAKE_FILTER_CYC) begin
              n.cnt = s.cnt + 8'h01;
            end
          end else if (s.cnt >= can_swk_pkg::WAKE_FILTER_CYC) begin
            n.st = can_swk_pkg::WS_REC;
          end else begin
            n.st = can_swk_pkg::WS_IDLE; // too short, glitch
          end
        end
        can_swk_pkg::WS_REC: begin
          if (bus_dominant_i) begin
            n.st = can_swk_pkg::WS_DOM2;
            n.cnt = 8'h01;
          end
        end
        can_swk_pkg::WS_DOM2: begin
          if (!bus_dominant_i) begin
            n.st = can_swk_pkg::WS_IDLE;
          end else if (s.cnt >= can_swk_pkg::WAKE_FILTER_CYC - 8'h01) begin
            n.hit = 1'b1;
            n.st = can_swk_pkg::WS_IDLE;
          end else begin
            n.cnt = s.cnt + 8'h01;
          end
        end
        default: begin
          n.st = can_swk_pkg::WS_IDLE;
        end
      endcase
    end
  end

  // register the state copy
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s <= '{st: can_swk_pkg::WS_IDLE, cnt: '0, hit: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign wake_pattern_o = s.hit;

  // a pattern ends on a dominant cycle and the detector restarts
  property p_wup_end;
    @(posedge clk_i) disable iff (!resetn_i)
    wake_pattern_o |-> $past(bus_dominant_i) && s.st == can_swk_pkg::WS_IDLE;
  endproperty
  a_wup_end: assert property (p_wup_end) else $error("pattern pulse without dominant end");

endmodule : wake_pattern_detect

`default_nettype wire

// >>> verification/can_bus_model.sv
// can_bus_model: bus side partner making frame, error, silence and wake events.
// assumes one-cycle commands from the bench on cmd_i.
`timescale 1ns/1ps
`default_nettype none
module can_bus_model (
  input wire logic clk_i,
  input wire logic [2:0] cmd_i, // 1 frame, 2 error, 3 silence, 4 pattern
  output logic frame_ok_o,
  output logic proto_err_o,
  output logic silence_o,
  output logic dominant_o,
  output logic rx_o
);
  logic [7:0] cnt = 8'h00; // wake pattern phase counter
  // event pulses one cycle after the command
  always_ff @(posedge clk_i) begin
    frame_ok_o <= (cmd_i == 3'h1);
    proto_err_o <= (cmd_i == 3'h2);
    silence_o <= (cmd_i == 3'h3);
    if (cmd_i == 3'h4) begin
      cnt <= 8'h01;
    end else if (cnt == 8'h78) begin
      cnt <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt + 8'h01;
    end
  end
  // 55 dominant, 10 recessive, 55 dominant: both above the filter time
  assign dominant_o = (cnt != 8'h00) && ((cnt < 8'h38) || (cnt > 8'h41));
  assign rx_o = ~dominant_o;
endmodule : can_bus_model
`default_nettype wire

// >>> verification/tb_can_swk_mode_ctrl.sv
// tb_can_swk_mode_ctrl: self-checking bench for the mode controller.
// assumes the bus model supplies frame, error, silence and bus level events; the bench drives the match inputs and the overflow.
`timescale 1ns/1ps
`default_nettype none
module tb_can_swk_mode_ctrl;
  logic clk_i = 1'b0, resetn_i = 1'b0, wr = 1'b0, rd = 1'b0, mt = 1'b0;
  logic [3:0] ad = 4'h0;
  logic [7:0] wd = 8'h00, rdat;
  logic [1:0] cm = 2'h0;
  logic [2:0] cmd = 3'h0;
  logic ovf = 1'b0, txd = 1'b0;
  logic fok, perr, sil, dom, rx, txb, rxd, irq, rst;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  can_swk_mode_ctrl uut (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(ad), .wdata_i(wd), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdat), .chip_mode_i(cm), .frame_ok_i(fok), .id_match_i(mt), .dlc_match_i(mt),
    .data_match_i(mt), .proto_err_i(perr), .silence_expired_i(sil), .protocol_error_count_overflow_i(ovf),
    .bus_dominant_i(dom), .bus_rx_i(rx), .txd_i(txd), .txd_bus_o(txb), .rxd_o(rxd),
    .wake_irq_o(irq), .restart_req_o(rst));
  can_bus_model bus (.clk_i(clk_i), .cmd_i(cmd), .frame_ok_o(fok), .proto_err_o(perr),
    .silence_o(sil), .dominant_o(dom), .rx_o(rx));
  // --------
  // helpers
  // --------
  initial forever #5 clk_i = ~clk_i;
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ad <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic wm(input logic [7:0] d);
    wr_reg(can_swk_pkg::MODE_ADDR, d);
  endtask : wm
  // read, mask and compare
  task automatic rr(input string nm, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    ad <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 chk(nm, e, rdat & m);
  endtask : rr
  task automatic ev(input logic [2:0] c, input int w);
    @(posedge clk_i);
    cmd <= c;
    @(posedge clk_i);
    cmd <= 3'h0;
    repeat (w) @(posedge clk_i);
  endtask : ev
  task automatic sc(input logic [1:0] m);
    @(posedge clk_i);
    cm <= m;
    repeat (2) @(posedge clk_i);
  endtask : sc
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  // --------
  // scenarios
  // --------
  task automatic t_decode;
    logic [7:0] st [5] = '{8'h01, 8'h04, 8'h02, 8'h02, 8'h01};
    rr("stat", can_swk_pkg::STATUS_ADDR, 8'hFF, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wm(8'(i));
      rr("mode", can_swk_pkg::MODE_ADDR, 8'hFF, 8'(i));
      if (i < 5) rr("state", can_swk_pkg::STATE_ADDR, 8'hFF, st[i]);
      if (i == 5) begin
        ev(3'h3, 1);
        rr("sil", can_swk_pkg::STATUS_ADDR, 8'h01, 8'h01);
        ev(3'h4, 130);
        rr("flags", can_swk_pkg::STATUS_ADDR, 8'h05, 8'h00);
      end
    end
    $display("decode done");
  endtask : t_decode
  task automatic t_stop;
    wm(8'h00);
    wm(8'h03);
    sc(can_swk_pkg::CHIP_STOP);
    wm(8'h01);
    rr("mode", can_swk_pkg::MODE_ADDR, 8'hFF, 8'h03);
    rr("state", can_swk_pkg::STATE_ADDR, 8'hFF, 8'h04);
    sc(can_swk_pkg::CHIP_NORMAL);
    wm(8'h00);
    wm(8'h03);
    ev(3'h1, 2);
    rr("sync", can_swk_pkg::STATUS_ADDR, 8'h02, 8'h02);
    ev(3'h2, 2);
    rr("sync", can_swk_pkg::STATUS_ADDR, 8'h02, 8'h00);
    chk("txd", 8'h00, 8'(txb));
    $display("stop and sync done");
  endtask : t_stop
  task automatic t_silence;
    wm(8'h00);
    wr_reg(can_swk_pkg::CTRL_ADDR, 8'h03);
    wm(8'h05);
    rr("state", can_swk_pkg::STATE_ADDR, 8'hFF, 8'h08);
    rr("armed", can_swk_pkg::STATUS_ADDR, 8'h0C, 8'h04);
    ev(3'h3, 2);
    rr("sil", can_swk_pkg::STATUS_ADDR, 8'h01, 8'h01);
    ev(3'h4, 130);
    rr("sil", can_swk_pkg::STATUS_ADDR, 8'h01, 8'h00);
    wm(8'h07);
    mt <= 1'b1;
    ev(3'h1, 0);
    @(posedge clk_i);
    #1 chk("irq", 8'h01, 8'(irq));
    chk("rxd", 8'h01, 8'(rxd));
    @(posedge clk_i);
    ovf <= 1'b1;
    @(posedge clk_i);
    ovf <= 1'b0;
    rr("err", can_swk_pkg::STATUS_ADDR, 8'h0C, 8'h08);
    $display("silence done");
  endtask : t_silence
  task automatic t_sleep_wake;
    int k = 0;
    wm(8'h02);
    @(posedge clk_i);
    #1 chk("txd", 8'h01, 8'(txb));
    wm(8'h03);
    sc(can_swk_pkg::CHIP_SLEEP);
    rr("mode", can_swk_pkg::MODE_ADDR, 8'hFF, 8'h01);
    sc(can_swk_pkg::CHIP_NORMAL);
    wm(8'h00);
    wr_reg(can_swk_pkg::CTRL_ADDR, 8'h03);
    wm(8'h06);
    sc(can_swk_pkg::CHIP_SLEEP);
    rr("mode", can_swk_pkg::MODE_ADDR, 8'hFF, 8'h05);
    rr("state", can_swk_pkg::STATE_ADDR, 8'hFF, 8'h08);
    rr("flags", can_swk_pkg::STATUS_ADDR, 8'h1C, 8'h14);
    ev(3'h1, 0);
    repeat (4) begin
      @(posedge clk_i);
      #1 if (rst === 1'b1) k++;
    end
    chk("restart", 8'h01, 8'(k));
    rr("flags", can_swk_pkg::STATUS_ADDR, 8'h1C, 8'h00);
    rr("mode", can_swk_pkg::MODE_ADDR, 8'hFF, 8'h05);
    $display("sleep wake done");
  endtask : t_sleep_wake
  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_decode();
    t_stop();
    t_silence();
    t_sleep_wake();
    tally_and_finish();
  end
endmodule : tb_can_swk_mode_ctrl
`default_nettype wire
